// [include/fault_regs_params.svh]
`ifndef FAULT_REGS_PARAMS_SVH
`define FAULT_REGS_PARAMS_SVH
`define ADDR_WRITE_ENABLE   8'h10
`define ADDR_HIGH_RAIL_RESP 8'hB8
`define ADDR_LOW_RAIL_OV    8'hB9
`define WRITE_ENABLE_OPEN   8'h00
`define WRITE_ENABLE_RESET  8'h00
`define RESP_RESET          8'h00
`define LOW_OV_RESET        3'h0
`define FIELD_OUT_OV        0
`define FIELD_OUT_UV        1
`define FIELD_IN_OV         2
`define FIELD_IN_UV         3
`define HICCUP_PERIOD_MS    500
`define CLOCK_MHZ           250
`define HICCUP_CYCLES       (`HICCUP_PERIOD_MS * 1000 * `CLOCK_MHZ)
`endif

// [include/fault_regs_pkg.sv]
package fault_regs_pkg;
    typedef enum logic [1:0]
    {
        RESP_FLAG    = 2'h0,
        RESP_HICCUP  = 2'h1,
        RESP_LATCH   = 2'h2,
        RESP_IGNORE  = 2'h3
    } response_t;
    typedef enum logic [2:0]
    {
        OV_115 = 3'h0,
        OV_110 = 3'h1,
        OV_120 = 3'h2,
        OV_125 = 3'h3,
        OV_130 = 3'h4,
        OV_135 = 3'h5,
        OV_140 = 3'h6,
        OV_145 = 3'h7
    } ov_threshold_t;
endpackage

// [hdl/fault_action.sv]
`timescale 1ns/1ns
`include "fault_regs_params.svh"
module fault_action
    import fault_regs_pkg::*;
#(
    parameter int HICCUP_CYCLES = `HICCUP_CYCLES
)
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clock_enable,
    input  wire logic       fault,
    input  wire logic [1:0] response,
    output logic            flag,
    output logic            shutdown
);
    typedef enum logic [1:0] {RUN, HICCUP_OFF, LATCHED} action_state_t;
    action_state_t state_reg;
    action_state_t state_next;
    logic [31:0]   count_reg;
    logic [31:0]   count_next;
    logic          flag_reg;
    wire           act_fault = fault && (response != RESP_IGNORE);
    wire           count_done = (count_reg == 32'(HICCUP_CYCLES - 1));
    always_comb
    begin
        state_next = state_reg;
        count_next = 32'h0;
        unique case (state_reg)
            RUN:
            begin
                if (act_fault && response == RESP_LATCH)
                    state_next = LATCHED;
                else if (act_fault && response == RESP_HICCUP)
                    state_next = HICCUP_OFF;
            end
            HICCUP_OFF:
            begin
                count_next = count_reg + 32'h1;
                if (count_done)
                begin
                    // Retry; a persisting fault re-enters off next cycle
                    state_next = RUN;
                    count_next = 32'h0;
                end
            end
            LATCHED:
                state_next = LATCHED;
        endcase
    end
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= RUN;
            count_reg <= 32'h0;
            flag_reg  <= 1'b0;
        end
        else if (clock_enable)
        begin
            state_reg <= state_next;
            count_reg <= count_next;
            flag_reg  <= act_fault;
        end
    end
    assign flag     = flag_reg;
    // Flag response never asserts shutdown, regulation continues
    assign shutdown = (state_reg != RUN);
endmodule

// [hdl/fault_response_config_regs.sv]
`timescale 1ns/1ns
`include "fault_regs_params.svh"
module fault_response_config_regs
    import fault_regs_pkg::*;
#(
    parameter int HICCUP_CYCLES = `HICCUP_CYCLES
)
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clock_enable,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    output logic            reg_ack,
    input  wire logic [3:0] fault_in,
    output logic [3:0]      fault_flag,
    output logic            shutdown,
    output logic [2:0]      low_rail_ov_threshold
);
    logic [7:0] write_enable_reg;
    logic [7:0] high_rail_fault_response_reg;
    logic [2:0] low_rail_ov_reg;
    logic [7:0] rdata_reg;
    logic       ack_reg;
    logic [3:0] fault_meta_reg;
    logic [3:0] fault_sync_reg;
    logic [3:0] field_shutdown;
    // Fault lines come from analog comparators, so synchronise
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            fault_meta_reg <= 4'h0;
            fault_sync_reg <= 4'h0;
        end
        else if (clock_enable)
        begin
            fault_meta_reg <= fault_in;
            fault_sync_reg <= fault_meta_reg;
        end
    end
    wire sel_enable = (reg_addr == `ADDR_WRITE_ENABLE);
    wire sel_resp   = (reg_addr == `ADDR_HIGH_RAIL_RESP);
    wire sel_ov     = (reg_addr == `ADDR_LOW_RAIL_OV);
    // Enable register itself stays writable, else it could never open
    wire unlocked   = (write_enable_reg == `WRITE_ENABLE_OPEN);
    wire wr_enable  = reg_write && sel_enable;
    wire wr_resp    = reg_write && sel_resp && unlocked;
    wire wr_ov      = reg_write && sel_ov && unlocked;
    wire [7:0] read_mux =
        sel_enable ? write_enable_reg :
        sel_resp   ? high_rail_fault_response_reg :
        sel_ov     ? {5'h0, low_rail_ov_reg} :
                     8'h00;
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            write_enable_reg             <= `WRITE_ENABLE_RESET;
            high_rail_fault_response_reg <= `RESP_RESET;
            low_rail_ov_reg              <= `LOW_OV_RESET;
            rdata_reg                    <= 8'h00;
            ack_reg                      <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (wr_enable)
                write_enable_reg <= reg_wdata;
            if (wr_resp)
                high_rail_fault_response_reg <= reg_wdata;
            if (wr_ov)
                low_rail_ov_reg <= reg_wdata[2:0];
            if (reg_read)
                rdata_reg <= read_mux;
            ack_reg <= reg_read || reg_write;
        end
    end
    assign reg_rdata             = rdata_reg;
    assign reg_ack               = ack_reg;
    assign low_rail_ov_threshold = low_rail_ov_reg;
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_field
            fault_action #(
                .HICCUP_CYCLES (HICCUP_CYCLES)
            ) u_action (
                .clock        (clock),
                .rst          (rst),
                .clock_enable (clock_enable),
                .fault        (fault_sync_reg[i]),
                .response     (high_rail_fault_response_reg[2*i +: 2]),
                .flag         (fault_flag[i]),
                .shutdown     (field_shutdown[i])
            );
        end
    endgenerate
    assign shutdown = |field_shutdown;
endmodule

// [tb/fault_regs_checker.sv]
`timescale 1ns/1ns
module fault_regs_checker #(parameter int HICCUP_CYCLES = 20)
(
    input wire logic       clock, rst, clock_enable, reg_write, reg_read,
    input wire logic       reg_ack, shutdown,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire logic [3:0] fault_in, fault_flag,
    input wire logic [2:0] low_rail_ov_threshold
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_ack; (reg_write || reg_read) && clock_enable
        |=> reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_b9; reg_read && clock_enable && reg_addr == 8'hB9
        |=> reg_rdata[7:3] == 5'h00; endproperty
    a_b9: assert property (p_b9) else $error("threshold upper bits");
    property p_unm; reg_read && clock_enable && reg_addr == 8'h20
        |=> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_thr; !reg_write |=> $stable(low_rail_ov_threshold); endproperty
    a_thr: assert property (p_thr) else $error("threshold moved");
    // Six idle samples cover the two-flop sync plus the flag register
    property p_flag; fault_in == 4'h0 [*6] |-> fault_flag == 4'h0; endproperty
    a_flag: assert property (p_flag) else $error("stale flag");
    property p_shut; $rose(shutdown) |-> $past(fault_in,3) != 4'h0; endproperty
    a_shut: assert property (p_shut) else $error("shutdown no fault");
    property p_rst; $fell(rst) |-> !shutdown && fault_flag == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("not cleared");
endmodule
bind fault_response_config_regs fault_regs_checker
    #(.HICCUP_CYCLES(HICCUP_CYCLES)) checker_i (.*);

// [tb/reg_host.sv]
`timescale 1ns/1ns
module reg_host
(
    input  wire logic       clock, reg_ack,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      reg_addr, reg_wdata,
    output logic            reg_write, reg_read
);
    initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h00000;
    // Held to the ack edge, so taken twice; the gap hides the second ack
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        int n = 0;
        repeat (2) @(negedge clock);
        {reg_addr, reg_wdata, reg_write, reg_read} = {a, d, w, !w};
        do @(posedge clock);
        while (reg_ack !== 1'h1 && ++n < 8);
        q = reg_rdata;
        @(negedge clock);
        {reg_addr, reg_wdata, reg_write, reg_read} = {~a, ~d, 2'h0};
    endtask
endmodule

// [tb/fault_response_config_regs_tb.sv]
`timescale 1ns/1ns
module fault_response_config_regs_tb;
    logic       clock = 1'h0, rst = 1'h1, clock_enable = 1'h1;
    logic       reg_write, reg_read, reg_ack, shutdown;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
    logic [3:0] fault_in = 4'h0, fault_flag;
    logic [2:0] low_rail_ov_threshold;
    int         bad_count = 0, checks = 0, cycles = 0;
    fault_response_config_regs #(.HICCUP_CYCLES(20)) DUT (.*);
    reg_host host (.*);
    initial forever #2 clock = ~clock;
    always @(posedge clock) if (++cycles == 3000) final_report;
    task automatic chk(input logic [7:0] got, want);
        checks++;
        bad_count += int'(got !== want);
        if (got !== want) $display("wrong value %0t got %h", $time, got);
    endtask
    task automatic rd(input logic [7:0] a, want);
        host.xfer(1'h0, a, 8'h00, q);
        chk(q, want);
    endtask
    task automatic hold(input logic [3:0] f, input int n);
        fault_in = f;
        repeat (n) @(negedge clock);
    endtask
    task automatic lock;
        rd(8'h20, 8'h00);
        host.xfer(1'h1, 8'h10, 8'h01, q);
        host.xfer(1'h1, 8'hB8, 8'hFF, q);
        rd(8'hB8, 8'h00);
        host.xfer(1'h1, 8'h10, 8'h00, q);
    endtask
    task automatic fields;
        for (int i = 0; i < 8; i++)
        begin
            host.xfer(1'h1, 8'hB9, 8'hF8 | 8'(i), q);
            rd(8'hB9, 8'(i));
            chk({5'h00, low_rail_ov_threshold}, 8'(i));
        end
        // Frozen clock enable must drop the write entirely
        clock_enable = 1'h0;
        host.xfer(1'h1, 8'hB9, 8'h00, q);
        clock_enable = 1'h1;
        chk({5'h00, low_rail_ov_threshold}, 8'h07);
        rd(8'hB9, 8'h07);
    endtask
    task automatic faults;
        host.xfer(1'h1, 8'hB8, 8'h9C, q);
        rd(8'hB8, 8'h9C);
        hold(4'h3, 6);
        chk({3'h0, shutdown, fault_flag}, 8'h01);
        hold(4'h4, 6);
        chk({3'h0, shutdown, fault_flag}, 8'h14);
        hold(4'h0, 28);
        chk({3'h0, shutdown, fault_flag}, 8'h00);
        hold(4'h8, 6);
        hold(4'h0, 60);
        chk({3'h0, shutdown, fault_flag}, 8'h10);
        rst = 1'h1;
        hold(4'h0, 6);
        rst = 1'h0;
        chk({3'h0, shutdown, fault_flag}, 8'h00);
        rd(8'hB8, 8'h00);
    endtask
    task automatic final_report;
        bad_count += int'(cycles >= 3000);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        hold(4'h0, 6);
        rst = 1'h0;
        lock;
        fields;
        faults;
        final_report;
    end
endmodule
